// ---- logic/acs_regbank.sv ----
// Charger status and converter options register bank
`timescale 1ns/1ps
// Behaviour
// - Mode 0 runs one set after start
// - Mode 1 repeats a set every second
// - Set completes ten milliseconds after begin
// - Start bit self-clears after one-shot set
// - Range bit selects full scale, resets one
// - Eight channel enables, reset disabled
// - Reserved option bits read back written
// - Status bit 15 mirrors input-good pin
// - Status bit 14 shows optimizer done
// - Status bit 12 shows voltage loop
// - Status bit 11 shows current loop
// - Bits 10, 9 show charge phase
// - Fault bits except system overvoltage latch until status read
// - Status register read-only apart from overvoltage clear, resets zero
// - System overvoltage latches, disables converter
// - Latch-off fault latches until status read
module acs_regbank
#(
  parameter int CONV_CYCLES   = acs_pkg::CONV_CYCLES,
  parameter int PERIOD_CYCLES = acs_pkg::PERIOD_CYCLES
)
(
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [acs_pkg::CMD_W-1:0]   cmd_code,
  input  wire logic                        wr_strobe,
  input  wire logic [acs_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                        rd_strobe,
  input  wire logic                        input_good_pin,
  input  wire logic                        input_optimizer_complete,
  input  wire logic                        input_voltage_loop_active,
  input  wire logic                        input_current_loop_active,
  input  wire logic                        fast_charge_phase,
  input  wire logic                        pre_charge_phase,
  input  wire logic                        input_overvoltage_fault,
  input  wire logic                        battery_overcurrent_fault,
  input  wire logic                        input_overcurrent_fault,
  input  wire logic                        system_overvoltage_flag,
  input  wire logic                        latch_off_fault,
  output logic [acs_pkg::DATA_W-1:0]       rd_data,
  output logic                             rd_valid,
  output logic                             repeat_mode_select,
  output logic                             range_select,
  output logic [acs_pkg::CHAN_N-1:0]       chan_en,
  output logic                             conv_busy,
  output logic                             result_update,
  output logic [acs_pkg::CHAN_N-1:0]       result_chan_mask,
  output logic                             converter_disable
);
  import acs_pkg::*;

  // Set wins over clear so an event in the clearing cycle survives
  function automatic logic latch_next(input logic set, input logic hold, input logic clr);
    latch_next = set | (hold & ~clr);
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync1_reg, sync1_next;
  logic [PIN_N-1:0] sync2_reg, sync2_next;

  assign pin_raw = {latch_off_fault, system_overvoltage_flag,
                    input_overcurrent_fault, battery_overcurrent_fault,
                    input_overvoltage_fault, pre_charge_phase, fast_charge_phase,
                    input_current_loop_active, input_voltage_loop_active,
                    input_optimizer_complete, input_good_pin};

  always_comb
  begin
    sync1_next = pin_raw;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic good_s, opt_s, vloop_s, iloop_s, fast_s, pre_s;
  logic in_ov_s, bat_oc_s, in_oc_s, sys_ov_s, latch_s;

  assign good_s   = sync2_reg[0];
  assign opt_s    = sync2_reg[1];
  assign vloop_s  = sync2_reg[2];
  assign iloop_s  = sync2_reg[3];
  assign fast_s   = sync2_reg[4];
  assign pre_s    = sync2_reg[5];
  assign in_ov_s  = sync2_reg[6];
  assign bat_oc_s = sync2_reg[7];
  assign in_oc_s  = sync2_reg[8];
  assign sys_ov_s = sync2_reg[9];
  assign latch_s  = sync2_reg[10];

  // ==========================================================
  // Access decode
  logic wr_opt, wr_stat, rd_stat, rd_opt;

  always_comb
  begin
    wr_opt  = 1'b0;
    wr_stat = 1'b0;
    rd_opt  = 1'b0;
    rd_stat = 1'b0;
    if (cmd_code == OPTIONS_OFFSET)
    begin
      wr_opt = wr_strobe;
      rd_opt = rd_strobe;
    end
    else if (cmd_code == STATUS_OFFSET)
    begin
      wr_stat = wr_strobe;
      rd_stat = rd_strobe;
    end
  end

  // ==========================================================
  // Options register
  logic [DATA_W-1:0] opt_reg, opt_next;
  logic              seq_done;

  always_comb
  begin
    opt_next = opt_reg;
    if (wr_opt)
      opt_next = wr_data;
    else if (seq_done)
      opt_next[OPT_START_BIT] = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      opt_reg <= OPTIONS_RESET;
    else
      opt_reg <= opt_next;
  end

  // ==========================================================
  // Sticky status flags
  logic in_ov_reg, in_ov_next;
  logic bat_oc_reg, bat_oc_next;
  logic in_oc_reg, in_oc_next;
  logic sys_ov_reg, sys_ov_next;
  logic latch_reg, latch_next_v;
  logic sys_ov_clr;

  // Clears also when the adapter goes away, not only on a host write
  assign sys_ov_clr = (wr_stat && !wr_data[ST_SYS_OV_BIT]) || !good_s;

  always_comb
  begin
    in_ov_next   = latch_next(in_ov_s, in_ov_reg, rd_stat);
    bat_oc_next  = latch_next(bat_oc_s, bat_oc_reg, rd_stat);
    in_oc_next   = latch_next(in_oc_s, in_oc_reg, rd_stat);
    latch_next_v = latch_next(latch_s, latch_reg, rd_stat);
    sys_ov_next  = latch_next(sys_ov_s, sys_ov_reg, sys_ov_clr);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_ov_reg  <= 1'b0;
      bat_oc_reg <= 1'b0;
      in_oc_reg  <= 1'b0;
      sys_ov_reg <= 1'b0;
      latch_reg  <= 1'b0;
    end
    else
    begin
      in_ov_reg  <= in_ov_next;
      bat_oc_reg <= bat_oc_next;
      in_oc_reg  <= in_oc_next;
      sys_ov_reg <= sys_ov_next;
      latch_reg  <= latch_next_v;
    end
  end

  // ==========================================================
  // Status word, read-only apart from the overvoltage clear
  logic [DATA_W-1:0] stat_word;

  always_comb
  begin
    stat_word                  = STATUS_RESET;
    stat_word[ST_PRESENT_BIT]  = good_s;
    stat_word[ST_OPT_DONE_BIT] = opt_s;
    stat_word[ST_VLOOP_BIT]    = vloop_s;
    stat_word[ST_ILOOP_BIT]    = iloop_s;
    stat_word[ST_FAST_BIT]     = fast_s;
    stat_word[ST_PRE_BIT]      = pre_s;
    stat_word[ST_IN_OV_BIT]    = in_ov_reg;
    stat_word[ST_BAT_OC_BIT]   = bat_oc_reg;
    stat_word[ST_IN_OC_BIT]    = in_oc_reg;
    stat_word[ST_SYS_OV_BIT]   = sys_ov_reg;
    stat_word[ST_LATCH_BIT]    = latch_reg;
  end

  // ==========================================================
  // Read port and output flops
  logic [DATA_W-1:0] rdat_reg, rdat_next;
  logic              rval_reg, rval_next;
  logic              dis_reg, dis_next;

  always_comb
  begin
    rdat_next = rdat_reg;
    rval_next = rd_strobe;
    dis_next  = sys_ov_next;
    if (rd_opt)
      rdat_next = opt_reg;
    else if (rd_stat)
      rdat_next = stat_word;
    else if (rd_strobe)
      rdat_next = '0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdat_reg <= '0;
      rval_reg <= 1'b0;
      dis_reg  <= 1'b0;
    end
    else
    begin
      rdat_reg <= rdat_next;
      rval_reg <= rval_next;
      dis_reg  <= dis_next;
    end
  end

  assign rd_data            = rdat_reg;
  assign rd_valid           = rval_reg;
  assign converter_disable  = dis_reg;
  assign repeat_mode_select = opt_reg[OPT_REPEAT_BIT];
  assign range_select       = opt_reg[OPT_RANGE_BIT];
  assign chan_en            = opt_reg[CHAN_N-1:0];

  // ==========================================================
  // Conversion sequencer
  acs_conv_seq
  #(
    .CONV_CYCLES   (CONV_CYCLES),
    .PERIOD_CYCLES (PERIOD_CYCLES)
  )
  u_seq
  (
    .clk          (clk),
    .rst_b        (rst_b),
    .start_req    (opt_reg[OPT_START_BIT]),
    .repeat_mode  (opt_reg[OPT_REPEAT_BIT]),
    .chan_en      (opt_reg[CHAN_N-1:0]),
    .busy         (conv_busy),
    .update_pulse (result_update),
    .update_mask  (result_chan_mask),
    .done_pulse   (seq_done)
  );

  // ==========================================================
  // Checks
  property p_start_clear;
    @(posedge clk) disable iff (!rst_b)
    (seq_done && !wr_opt) |=> !opt_reg[OPT_START_BIT];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit stuck");

  property p_fault_set;
    @(posedge clk) disable iff (!rst_b)
    in_oc_s |=> in_oc_reg ##1 (in_oc_reg || $past(rd_stat));
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  property p_fault_rdclr;
    @(posedge clk) disable iff (!rst_b)
    (rd_stat && !in_ov_s && !bat_oc_s) |=> !in_ov_reg && !bat_oc_reg
      && (rd_data[ST_IN_OV_BIT] == $past(in_ov_reg));
  endproperty
  a_fault_rdclr: assert property (p_fault_rdclr) else $error("fault read clear");

  property p_present;
    @(posedge clk) disable iff (!rst_b)
    rd_stat |=> rd_valid && (rd_data[ST_PRESENT_BIT] == $past(good_s));
  endproperty
  a_present: assert property (p_present) else $error("present bit wrong");

  property p_sysov_dis;
    @(posedge clk) disable iff (!rst_b)
    sys_ov_s |=> converter_disable;
  endproperty
  a_sysov_dis: assert property (p_sysov_dis) else $error("converter not disabled");

  property p_sysov_unplug;
    @(posedge clk) disable iff (!rst_b)
    (sys_ov_reg && !good_s && !sys_ov_s) |=> !sys_ov_reg ##1 !converter_disable;
  endproperty
  a_sysov_unplug: assert property (p_sysov_unplug) else $error("overvoltage not cleared");

  property p_opt_write;
    @(posedge clk) disable iff (!rst_b)
    wr_opt |=> (range_select == $past(wr_data[OPT_RANGE_BIT]))
      && (opt_reg[OPT_RSVD_HI:OPT_RSVD_LO] == $past(wr_data[OPT_RSVD_HI:OPT_RSVD_LO]))
      && (chan_en == $past(wr_data[CHAN_N-1:0]));
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("options not stored");

  property p_latch_hold;
    @(posedge clk) disable iff (!rst_b)
    (latch_reg && !rd_stat) |=> latch_reg;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch-off lost");

  property p_stat_ro;
    @(posedge clk) disable iff (!rst_b)
    (wr_stat && !rd_stat) |=> (bat_oc_reg == $past(bat_oc_reg | bat_oc_s));
  endproperty
  a_stat_ro: assert property (p_stat_ro) else $error("status bit written");

  c_oneshot: cover property (@(posedge clk) disable iff (!rst_b)
    seq_done ##1 !opt_reg[OPT_START_BIT]);
  c_rdclr: cover property (@(posedge clk) disable iff (!rst_b)
    in_ov_reg ##1 rd_stat ##1 !in_ov_reg);
  c_sysov_wr: cover property (@(posedge clk) disable iff (!rst_b)
    sys_ov_reg ##1 (wr_stat && !sys_ov_s) ##1 !sys_ov_reg);
endmodule

// ---- logic/acs_pkg.sv ----
// Constants shared by the charger register bank and its conversion sequencer
package acs_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W  = 16;
  localparam int CMD_W   = 8;
  localparam int CHAN_N  = 8;
  localparam int CNT_W   = 24;
  localparam int PIN_N   = 11;

  // ==========================================================
  // Register offsets and reset values
  localparam logic [7:0]  STATUS_OFFSET  = 8'h20;
  localparam logic [7:0]  OPTIONS_OFFSET = 8'h35;
  localparam logic [15:0] OPTIONS_RESET  = 16'h2000;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;

  // ==========================================================
  // Options register fields
  localparam int OPT_REPEAT_BIT = 15;
  localparam int OPT_START_BIT  = 14;
  localparam int OPT_RANGE_BIT  = 13;
  localparam int OPT_RSVD_HI    = 12;
  localparam int OPT_RSVD_LO    = 8;

  // ==========================================================
  // Status register fields
  localparam int ST_PRESENT_BIT  = 15;
  localparam int ST_OPT_DONE_BIT = 14;
  localparam int ST_VLOOP_BIT    = 12;
  localparam int ST_ILOOP_BIT    = 11;
  localparam int ST_FAST_BIT     = 10;
  localparam int ST_PRE_BIT      = 9;
  localparam int ST_IN_OV_BIT    = 7;
  localparam int ST_BAT_OC_BIT   = 6;
  localparam int ST_IN_OC_BIT    = 5;
  localparam int ST_SYS_OV_BIT   = 4;
  localparam int ST_LATCH_BIT    = 2;

  // ==========================================================
  // Timing at the 10 MHz system clock
  localparam int CLK_HZ        = 10_000_000;
  localparam int CONV_TIME_MS  = 10;
  localparam int PERIOD_TIME_S = 1;
  localparam int CONV_CYCLES   = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int PERIOD_CYCLES = CLK_HZ * PERIOD_TIME_S;
endpackage

// ---- logic/acs_conv_seq.sv ----
// Conversion set sequencer: one-shot and repeating sets with timing
`timescale 1ns/1ps
module acs_conv_seq
#(
  parameter int CONV_CYCLES   = acs_pkg::CONV_CYCLES,
  parameter int PERIOD_CYCLES = acs_pkg::PERIOD_CYCLES
)
(
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        start_req,
  input  wire logic                        repeat_mode,
  input  wire logic [acs_pkg::CHAN_N-1:0]  chan_en,
  output logic                             busy,
  output logic                             update_pulse,
  output logic [acs_pkg::CHAN_N-1:0]       update_mask,
  output logic                             done_pulse
);
  import acs_pkg::*;

  typedef enum logic [2:0]
  {
    SEQ_IDLE = 3'b001,
    SEQ_CONV = 3'b010,
    SEQ_WAIT = 3'b100
  } acs_seq_state_t;

  acs_seq_state_t      state_reg, state_next;
  logic [CNT_W-1:0]    tick_reg, tick_next;
  logic [CHAN_N-1:0]   mask_reg, mask_next;
  logic                busy_reg, busy_next;
  logic                upd_reg, upd_next;
  logic                done_reg, done_next;
  logic [CNT_W-1:0]    conv_last;
  logic [CNT_W-1:0]    period_last;

  // Period counts start to start, so it must exceed the conversion time
  assign conv_last   = CNT_W'(CONV_CYCLES - 1);
  assign period_last = CNT_W'(PERIOD_CYCLES - 1);

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    tick_next  = tick_reg + CNT_W'(1);
    mask_next  = mask_reg;
    upd_next   = 1'b0;
    done_next  = 1'b0;
    case (state_reg)
      SEQ_IDLE:
      begin
        tick_next = '0;
        // Start bit is still set while done clears it, so hold off or one-shot runs twice
        if (start_req && !done_reg)
        begin
          state_next = SEQ_CONV;
          mask_next  = chan_en;
        end
      end
      SEQ_CONV:
      begin
        if (tick_reg == conv_last)
        begin
          upd_next = 1'b1;
          if (repeat_mode && start_req)
            state_next = SEQ_WAIT;
          else
          begin
            state_next = SEQ_IDLE;
            done_next  = ~repeat_mode;
          end
        end
      end
      SEQ_WAIT:
      begin
        if (!(repeat_mode && start_req))
          state_next = SEQ_IDLE;
        else if (tick_reg == period_last)
        begin
          state_next = SEQ_CONV;
          tick_next  = '0;
          mask_next  = chan_en;
        end
      end
      default:
      begin
        state_next = SEQ_IDLE;
      end
    endcase
    busy_next = (state_next != SEQ_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= SEQ_IDLE;
      tick_reg  <= '0;
      mask_reg  <= '0;
      busy_reg  <= 1'b0;
      upd_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      tick_reg  <= tick_next;
      mask_reg  <= mask_next;
      busy_reg  <= busy_next;
      upd_reg   <= upd_next;
      done_reg  <= done_next;
    end
  end

  assign busy         = busy_reg;
  assign update_pulse = upd_reg;
  assign update_mask  = mask_reg;
  assign done_pulse   = done_reg;

  // ==========================================================
  // Checks
  property p_conv_time;
    @(posedge clk) disable iff (!rst_b)
    upd_reg |-> ($past(state_reg) == SEQ_CONV) && ($past(tick_reg) == conv_last);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("update not at conversion end");

  property p_period;
    @(posedge clk) disable iff (!rst_b)
    (state_reg == SEQ_WAIT && tick_reg == period_last && repeat_mode && start_req)
      |=> (state_reg == SEQ_CONV) && (tick_reg == '0);
  endproperty
  a_period: assert property (p_period) else $error("repeat set not restarted");

  property p_oneshot_end;
    @(posedge clk) disable iff (!rst_b)
    (upd_reg && !$past(repeat_mode)) |-> (state_reg == SEQ_IDLE) && done_reg;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot did not stop");

  property p_mask_hold;
    @(posedge clk) disable iff (!rst_b)
    (state_reg == SEQ_CONV && $past(state_reg) == SEQ_CONV) |-> $stable(mask_reg);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("channel mask moved");

  c_repeat: cover property (@(posedge clk) disable iff (!rst_b)
    (state_reg == SEQ_WAIT) ##1 (state_reg == SEQ_CONV));
endmodule

// ---- test/acs_host_model.sv ----
// Host-side model issuing register commands to the charger register bank
`timescale 1ns/1ps
module acs_host_model
(
  input  wire logic                       clk,
  input  wire logic [acs_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       rd_valid,
  output logic      [acs_pkg::CMD_W-1:0]  cmd_code,
  output logic                            wr_strobe,
  output logic      [acs_pkg::DATA_W-1:0] wr_data,
  output logic                            rd_strobe
);
  import acs_pkg::*;
  logic              last_valid;
  // ==========================================================
  // Idle bus
  initial
  begin
    cmd_code   = 8'h00;
    wr_strobe  = 1'b0;
    wr_data    = 16'h0000;
    rd_strobe  = 1'b0;
    last_valid = 1'b0;
  end
  // ==========================================================
  // Command transfers
  task automatic reg_write(input logic [CMD_W-1:0] cmd, input logic [DATA_W-1:0] data);
    @(posedge clk);
    #1;
    cmd_code  = cmd;
    wr_data   = data;
    wr_strobe = 1'b1;
    @(posedge clk);
    #1;
    wr_strobe = 1'b0;
    // Released lines show garbage, never the last word
    wr_data   = ~data;
    cmd_code  = ~cmd;
  endtask
  task automatic reg_read(input logic [CMD_W-1:0] cmd, output logic [DATA_W-1:0] data);
    @(posedge clk);
    #1;
    cmd_code  = cmd;
    rd_strobe = 1'b1;
    @(posedge clk);
    #1;
    rd_strobe  = 1'b0;
    cmd_code   = ~cmd;
    last_valid = rd_valid;
    data       = rd_data;
  endtask
  // Small scale for low supply, start bit set to launch a set
  task automatic start_set(input logic rep, input logic low_supply, input logic [7:0] en);
    reg_write(OPTIONS_OFFSET, {rep, 1'b1, ~low_supply, 5'h00, en});
  endtask
endmodule

// ---- test/tb_acs_regbank.sv ----
// Self-checking bench for the charger status and options register bank
`timescale 1ns/1ps
module tb_acs_regbank;
  import acs_pkg::*;
  localparam int CONV_N = 20;
  localparam int PER_N  = 60;
  logic              clk;
  logic              rst_b;
  logic [CMD_W-1:0]  cmd_code;
  logic              wr_strobe;
  logic [DATA_W-1:0] wr_data;
  logic              rd_strobe;
  logic [DATA_W-1:0] rd_data;
  logic              rd_valid;
  logic              repeat_mode_select;
  logic              range_select;
  logic [CHAN_N-1:0] chan_en;
  logic              conv_busy;
  logic              result_update;
  logic [CHAN_N-1:0] result_chan_mask;
  logic              converter_disable;
  logic [5:0]        live;
  logic [4:0]        fault;
  logic [DATA_W-1:0] w;
  logic [CHAN_N-1:0] en;
  int                err_count;
  int                total_checks;
  int                seed;
  int                n;
  int                fbit [5];
  // ==========================================================
  // Clock and instances
  always #50 clk = ~clk;
  acs_regbank #(.CONV_CYCLES(CONV_N), .PERIOD_CYCLES(PER_N)) u_acs_regbank
  (
    .clk                       (clk),
    .rst_b                     (rst_b),
    .cmd_code                  (cmd_code),
    .wr_strobe                 (wr_strobe),
    .wr_data                   (wr_data),
    .rd_strobe                 (rd_strobe),
    .input_good_pin            (live[5]),
    .input_optimizer_complete  (live[4]),
    .input_voltage_loop_active (live[3]),
    .input_current_loop_active (live[2]),
    .fast_charge_phase         (live[1]),
    .pre_charge_phase          (live[0]),
    .input_overvoltage_fault   (fault[4]),
    .battery_overcurrent_fault (fault[3]),
    .input_overcurrent_fault   (fault[2]),
    .system_overvoltage_flag   (fault[1]),
    .latch_off_fault           (fault[0]),
    .rd_data                   (rd_data),
    .rd_valid                  (rd_valid),
    .repeat_mode_select        (repeat_mode_select),
    .range_select              (range_select),
    .chan_en                   (chan_en),
    .conv_busy                 (conv_busy),
    .result_update             (result_update),
    .result_chan_mask          (result_chan_mask),
    .converter_disable         (converter_disable)
  );
  acs_host_model u_acs_host_model
  (
    .clk       (clk),
    .rd_data   (rd_data),
    .rd_valid  (rd_valid),
    .cmd_code  (cmd_code),
    .wr_strobe (wr_strobe),
    .wr_data   (wr_data),
    .rd_strobe (rd_strobe)
  );
  // ==========================================================
  // Helpers
  function automatic logic [15:0] exp_live(input logic [5:0] p);
    return {p[5], p[4], 1'b0, p[3], p[2], p[1], p[0], 9'h000};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic read_chk(input logic [7:0] cmd, input logic [15:0] exp, input string what);
    logic [15:0] d;
    u_acs_host_model.reg_read(cmd, d);
    check("read valid", 16'(u_acs_host_model.last_valid), 16'h0001);
    check(what, d, exp);
  endtask
  task automatic wait_update(input int bound, output int cnt);
    cnt = 0;
    do
    begin
      tick(1);
      cnt++;
    end
    while (result_update !== 1'b1 && cnt < bound);
    if (result_update !== 1'b1)
    begin
      check("update timeout", 16'(result_update), 16'h0001);
      close_out();
    end
  endtask
  task automatic count_updates(input int k, output int cnt);
    cnt = 0;
    repeat (k)
    begin
      tick(1);
      if (result_update === 1'b1)
        cnt++;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    live = 6'h00;
    fault = 5'h00;
    seed = 19;
    err_count = 0;
    total_checks = 0;
    fbit = '{7, 6, 5, 4, 2};
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    read_chk(OPTIONS_OFFSET, OPTIONS_RESET, "options reset");
    read_chk(STATUS_OFFSET, STATUS_RESET, "status reset");
    check("range reset", 16'(range_select), 16'h0001);
    check("enables reset", 16'(chan_en), 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      w = (i == 0) ? 16'h1F00 : (i == 1) ? 16'h0000 : 16'($random(seed));
      w[OPT_START_BIT] = 1'b0;
      u_acs_host_model.reg_write(OPTIONS_OFFSET, w);
      read_chk(OPTIONS_OFFSET, w, "options readback");
      check("range out", 16'(range_select), 16'(w[13]));
      check("enables out", 16'(chan_en), 16'(w[7:0]));
      check("mode out", 16'(repeat_mode_select), 16'(w[15]));
    end
    u_acs_host_model.reg_write(STATUS_OFFSET, 16'hFFEF);
    read_chk(STATUS_OFFSET, 16'h0000, "status write ignored");
    u_acs_host_model.reg_write(8'h33, 16'h0000);
    read_chk(8'h33, 16'h0000, "unmapped read");
    read_chk(OPTIONS_OFFSET, w, "options after unmapped write");
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      live = (i == 0) ? 6'h3F : 6'($random(seed));
      tick(3);
      read_chk(STATUS_OFFSET, exp_live(live), "live status");
    end
    $display("test live status done");
    live = 6'h20;
    for (int i = 0; i < 5; i++)
    begin
      if (i == 3)
        continue;
      fault = 5'h10 >> i;
      tick(3);
      fault = 5'h00;
      tick(4);
      read_chk(STATUS_OFFSET, 16'h8000 | (16'h0001 << fbit[i]), "fault latched");
      read_chk(STATUS_OFFSET, 16'h8000, "fault cleared by read");
    end
    // Overvoltage latch: cleared by writing zero, or by adapter removal
    fault = 5'h02;
    tick(4);
    check("converter off", 16'(converter_disable), 16'h0001);
    fault = 5'h00;
    tick(4);
    read_chk(STATUS_OFFSET, 16'h8010, "overvoltage latched");
    check("still off", 16'(converter_disable), 16'h0001);
    u_acs_host_model.reg_write(STATUS_OFFSET, 16'h0000);
    tick(3);
    check("converter on", 16'(converter_disable), 16'h0000);
    fault = 5'h02;
    tick(4);
    fault = 5'h00;
    live = 6'h00;
    tick(5);
    check("adapter removed", 16'(converter_disable), 16'h0000);
    read_chk(STATUS_OFFSET, 16'h0000, "status idle");
    live = 6'h20;
    $display("test faults done");
    en = 8'($random(seed)) | 8'h01;
    u_acs_host_model.start_set(1'b0, 1'b0, en);
    tick(5);
    check("busy in set", 16'(conv_busy), 16'h0001);
    // Mid-set enable change must not reach this set
    u_acs_host_model.reg_write(OPTIONS_OFFSET, {3'b010, 5'h00, ~en});
    wait_update(CONV_N + 10, n);
    check("one-shot latency", 16'(n + 7), 16'(CONV_N + 1));
    check("set mask", 16'(result_chan_mask), 16'(en));
    read_chk(OPTIONS_OFFSET, {3'b000, 5'h00, ~en}, "start self clear");
    count_updates(2 * PER_N, n);
    check("single set", 16'(n), 16'h0000);
    $display("test one-shot done");
    u_acs_host_model.start_set(1'b1, 1'b1, en);
    wait_update(CONV_N + 10, n);
    wait_update(PER_N + 10, n);
    check("repeat period", 16'(n), 16'(PER_N));
    check("repeat mask", 16'(result_chan_mask), 16'(en));
    u_acs_host_model.reg_write(OPTIONS_OFFSET, 16'h2000 | 16'(en));
    tick(2 * PER_N);
    check("repeat stopped", 16'(conv_busy), 16'h0000);
    count_updates(2 * PER_N, n);
    check("no update after stop", 16'(n), 16'h0000);
    $display("test repeat done");
    close_out();
  end
endmodule
